// ### hw/pim_pkg.sv
// Package of constants and types for the peripheral interconnect matrix
package pim_pkg;

    // ------------------------------------------------------------
    // Route widths
    // ------------------------------------------------------------
    localparam int PIM_TIMERS      = 8;
    localparam int PIM_BLANKS      = 2;
    localparam int PIM_IR_FEEDS    = 2;
    localparam int PIM_COMPARATORS = 2;
    localparam int PIM_CONVERTERS  = 3;
    localparam int PIM_CAL_EVENTS  = 2;
    localparam int PIM_CLK_SOURCES = 6;
    localparam int PIM_PIN_TRIGS   = 4;
    localparam int PIM_MODE_BITS   = 3;

    // ------------------------------------------------------------
    // Power mode codes from the power controller
    // ------------------------------------------------------------
    localparam logic [2:0] PIM_CODE_RUN      = 3'h0;
    localparam logic [2:0] PIM_CODE_SLEEP    = 3'h1;
    localparam logic [2:0] PIM_CODE_LP_RUN   = 3'h2;
    localparam logic [2:0] PIM_CODE_LP_SLEEP = 3'h3;
    localparam logic [2:0] PIM_CODE_STOP0    = 3'h4;
    localparam logic [2:0] PIM_CODE_STOP1    = 3'h5;
    localparam logic [2:0] PIM_CODE_STOP2    = 3'h6;

    // ------------------------------------------------------------
    // Tracked power mode, one-hot
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        PIM_MODE_RUN      = 7'h01,
        PIM_MODE_SLEEP    = 7'h02,
        PIM_MODE_LP_RUN   = 7'h04,
        PIM_MODE_LP_SLEEP = 7'h08,
        PIM_MODE_STOP0    = 7'h10,
        PIM_MODE_STOP1    = 7'h20,
        PIM_MODE_STOP2    = 7'h40
    } pim_mode_type;

    localparam pim_mode_type PIM_MODE_RESET = PIM_MODE_RUN;

endpackage

// ### hw/pim_gate_if.sv
// Interface carrying the tracked mode and the path enables
`timescale 1ns/1ns
interface pim_gate_if;
    import pim_pkg::*;

    pim_mode_type mode;
    logic         en_active;
    logic         en_full;
    logic         en_lp1;
    logic         en_lp2;

    modport decoder (
        input  mode,
        output en_active,
        output en_full,
        output en_lp1,
        output en_lp2
    );

    modport router (
        output mode,
        input  en_active,
        input  en_full,
        input  en_lp1,
        input  en_lp2
    );
endinterface

// ### hw/pim_mode_gate.sv
// Decoder from tracked power mode to per-class path enables
`timescale 1ns/1ns
module pim_mode_gate (
    pim_gate_if.decoder gate
);
    import pim_pkg::*;

    // ------------------------------------------------------------
    // Enable classes
    // ------------------------------------------------------------
    always_comb begin
        gate.en_active = 1'b0;
        gate.en_full   = 1'b0;
        gate.en_lp1    = 1'b0;
        gate.en_lp2    = 1'b0;
        case (gate.mode)
            PIM_MODE_RUN, PIM_MODE_SLEEP: begin
                gate.en_active = 1'b1;
                gate.en_full   = 1'b1;
                gate.en_lp1    = 1'b1;
                gate.en_lp2    = 1'b1;
            end
            PIM_MODE_LP_RUN, PIM_MODE_LP_SLEEP: begin
                gate.en_active = 1'b1;
                gate.en_lp1    = 1'b1;
                gate.en_lp2    = 1'b1;
            end
            PIM_MODE_STOP0, PIM_MODE_STOP1: begin
                gate.en_lp1    = 1'b1;
                gate.en_lp2    = 1'b1;
            end
            PIM_MODE_STOP2: begin
                // Only the first low-power timer keeps its routes
                gate.en_lp1    = 1'b1;
            end
            default: begin
                // Unknown mode blocks everything
                gate.en_active = 1'b0;
            end
        endcase
    end

endmodule

// ### hw/pim_matrix.sv
// Peripheral interconnect matrix gated by the system power mode
`timescale 1ns/1ns
module pim_matrix (
    // Clock and reset
    input  wire logic                                  i_clk,
    input  wire logic                                  i_reset,
    // Power mode
    input  wire logic [pim_pkg::PIM_MODE_BITS-1:0]     i_power_mode,
    // Timer sources
    input  wire logic [pim_pkg::PIM_TIMERS-1:0]        i_timer_trgo,
    input  wire logic [pim_pkg::PIM_BLANKS-1:0]        i_timer_blank,
    input  wire logic [pim_pkg::PIM_IR_FEEDS-1:0]      i_small_tim_oc,
    // Analog, calendar, clock and pin sources
    input  wire logic [pim_pkg::PIM_COMPARATORS-1:0]   i_comp_out,
    input  wire logic [pim_pkg::PIM_CONVERTERS-1:0]    i_adc_awd,
    input  wire logic                                  i_cal_event,
    input  wire logic [pim_pkg::PIM_CAL_EVENTS-1:0]    i_cal_alarm,
    input  wire logic [pim_pkg::PIM_CLK_SOURCES-1:0]   i_clk_src,
    input  wire logic                                  i_usb_sof,
    input  wire logic [pim_pkg::PIM_PIN_TRIGS-1:0]     i_pin_trig,
    // Fault sources
    input  wire logic                                  i_clk_fail,
    input  wire logic                                  i_hard_fault,
    input  wire logic                                  i_ram_parity,
    input  wire logic                                  i_flash_ecc,
    input  wire logic                                  i_pvd_event,
    input  wire logic                                  i_filter_fault,
    // Timer destinations
    output logic      [pim_pkg::PIM_TIMERS-1:0]        o_timer_sync,
    output logic      [pim_pkg::PIM_TIMERS-1:0]        o_xfer_trig,
    output logic      [pim_pkg::PIM_BLANKS-1:0]        o_comp_blank,
    output logic      [pim_pkg::PIM_IR_FEEDS-1:0]      o_ir_feed,
    output logic      [pim_pkg::PIM_COMPARATORS-1:0]   o_comp_timer,
    output logic      [pim_pkg::PIM_CONVERTERS-1:0]    o_awd_trig,
    output logic                                       o_cal_timer,
    output logic      [pim_pkg::PIM_CLK_SOURCES-1:0]   o_clk_meas,
    output logic                                       o_sof_trig,
    output logic      [pim_pkg::PIM_PIN_TRIGS-1:0]     o_pin_timer,
    output logic                                       o_break_adv,
    output logic                                       o_break_small,
    // Low-power timer destinations
    output logic      [pim_pkg::PIM_COMPARATORS-1:0]   o_comp_lp1,
    output logic      [pim_pkg::PIM_COMPARATORS-1:0]   o_comp_lp2,
    output logic      [pim_pkg::PIM_CAL_EVENTS-1:0]    o_cal_lp1,
    output logic      [pim_pkg::PIM_CAL_EVENTS-1:0]    o_cal_lp2,
    output logic      [pim_pkg::PIM_PIN_TRIGS-1:0]     o_pin_lp1,
    output logic      [pim_pkg::PIM_PIN_TRIGS-1:0]     o_pin_lp2
);
    import pim_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pim_mode_type                  mode;
        logic [PIM_TIMERS-1:0]         tim_sync;
        logic [PIM_TIMERS-1:0]         xfer;
        logic [PIM_BLANKS-1:0]         blank;
        logic [PIM_IR_FEEDS-1:0]       ir;
        logic [PIM_COMPARATORS-1:0]    comp_tim;
        logic [PIM_CONVERTERS-1:0]     awd;
        logic                          cal_tim;
        logic [PIM_CLK_SOURCES-1:0]    clk_meas;
        logic                          sof;
        logic [PIM_PIN_TRIGS-1:0]      pin_tim;
        logic                          brk_adv;
        logic                          brk_small;
        logic [PIM_COMPARATORS-1:0]    comp_lp1;
        logic [PIM_COMPARATORS-1:0]    comp_lp2;
        logic [PIM_CAL_EVENTS-1:0]     cal_lp1;
        logic [PIM_CAL_EVENTS-1:0]     cal_lp2;
        logic [PIM_PIN_TRIGS-1:0]      pin_lp1;
        logic [PIM_PIN_TRIGS-1:0]      pin_lp2;
    } pim_state_type;

    pim_state_type state_q;
    pim_state_type state_d;
    logic          fault_any;

    pim_gate_if gate ();

    pim_mode_gate u_gate (
        .gate (gate.decoder)
    );

    assign gate.mode = state_q.mode;

    // Every fault source shares one break line per timer group
    assign fault_any = i_clk_fail | i_hard_fault | i_ram_parity
                     | i_flash_ecc | i_pvd_event | i_filter_fault
                     | (|i_comp_out);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // Mode tracking; an unknown code keeps the last mode
        case (i_power_mode)
            PIM_CODE_RUN:      state_d.mode = PIM_MODE_RUN;
            PIM_CODE_SLEEP:    state_d.mode = PIM_MODE_SLEEP;
            PIM_CODE_LP_RUN:   state_d.mode = PIM_MODE_LP_RUN;
            PIM_CODE_LP_SLEEP: state_d.mode = PIM_MODE_LP_SLEEP;
            PIM_CODE_STOP0:    state_d.mode = PIM_MODE_STOP0;
            PIM_CODE_STOP1:    state_d.mode = PIM_MODE_STOP1;
            PIM_CODE_STOP2:    state_d.mode = PIM_MODE_STOP2;
            default:           state_d.mode = state_q.mode;
        endcase
        // Masking with the enable forces a blocked route low
        state_d.tim_sync  = i_timer_trgo & {PIM_TIMERS{gate.en_active}};
        state_d.xfer      = i_timer_trgo & {PIM_TIMERS{gate.en_active}};
        state_d.blank     = i_timer_blank & {PIM_BLANKS{gate.en_active}};
        state_d.ir        = i_small_tim_oc & {PIM_IR_FEEDS{gate.en_active}};
        state_d.comp_tim  = i_comp_out & {PIM_COMPARATORS{gate.en_active}};
        state_d.awd       = i_adc_awd & {PIM_CONVERTERS{gate.en_active}};
        state_d.cal_tim   = i_cal_event & gate.en_active;
        state_d.clk_meas  = i_clk_src & {PIM_CLK_SOURCES{gate.en_active}};
        state_d.sof       = i_usb_sof & gate.en_full;
        state_d.pin_tim   = i_pin_trig & {PIM_PIN_TRIGS{gate.en_active}};
        state_d.brk_adv   = fault_any & gate.en_active;
        state_d.brk_small = fault_any & gate.en_active;
        state_d.comp_lp1  = i_comp_out & {PIM_COMPARATORS{gate.en_lp1}};
        state_d.comp_lp2  = i_comp_out & {PIM_COMPARATORS{gate.en_lp2}};
        state_d.cal_lp1   = i_cal_alarm & {PIM_CAL_EVENTS{gate.en_lp1}};
        state_d.cal_lp2   = i_cal_alarm & {PIM_CAL_EVENTS{gate.en_lp2}};
        state_d.pin_lp1   = i_pin_trig & {PIM_PIN_TRIGS{gate.en_lp1}};
        state_d.pin_lp2   = i_pin_trig & {PIM_PIN_TRIGS{gate.en_lp2}};
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q      <= '0;
            state_q.mode <= PIM_MODE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Registered outputs cost one cycle but stop mode glitches
    assign o_timer_sync  = state_q.tim_sync;
    assign o_xfer_trig   = state_q.xfer;
    assign o_comp_blank  = state_q.blank;
    assign o_ir_feed     = state_q.ir;
    assign o_comp_timer  = state_q.comp_tim;
    assign o_awd_trig    = state_q.awd;
    assign o_cal_timer   = state_q.cal_tim;
    assign o_clk_meas    = state_q.clk_meas;
    assign o_sof_trig    = state_q.sof;
    assign o_pin_timer   = state_q.pin_tim;
    assign o_break_adv   = state_q.brk_adv;
    assign o_break_small = state_q.brk_small;
    assign o_comp_lp1    = state_q.comp_lp1;
    assign o_comp_lp2    = state_q.comp_lp2;
    assign o_cal_lp1     = state_q.cal_lp1;
    assign o_cal_lp2     = state_q.cal_lp2;
    assign o_pin_lp1     = state_q.pin_lp1;
    assign o_pin_lp2     = state_q.pin_lp2;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    mode_track_a: assert property (
        i_power_mode == PIM_CODE_STOP2 |=> gate.mode == PIM_MODE_STOP2)
        else $error("mode not tracked");

    timer_sync_a: assert property (
        gate.en_active |=> o_timer_sync == $past(i_timer_trgo))
        else $error("timer sync not passed");

    xfer_trig_a: assert property (
        gate.mode == PIM_MODE_STOP1 |=> o_xfer_trig == '0)
        else $error("transfer trigger leaked in stop");

    blank_path_a: assert property (
        gate.en_active |=> o_comp_blank == $past(i_timer_blank))
        else $error("blanking not passed");

    ir_feed_a: assert property (
        gate.mode == PIM_MODE_LP_SLEEP
        |=> o_ir_feed == $past(i_small_tim_oc))
        else $error("infrared feed blocked");

    comp_timer_a: assert property (
        !gate.en_active |=> o_comp_timer == '0)
        else $error("comparator route leaked");

    comp_lptim_a: assert property (
        gate.mode == PIM_MODE_STOP0 |=> o_comp_lp1 == $past(i_comp_out)
        && o_comp_lp2 == $past(i_comp_out))
        else $error("comparator to low-power timer blocked");

    awd_trig_a: assert property (
        gate.en_active |=> o_awd_trig == $past(i_adc_awd))
        else $error("watchdog trigger lost");

    cal_timer_a: assert property (
        !gate.en_active |=> !o_cal_timer)
        else $error("calendar event leaked");

    cal_lptim_a: assert property (
        gate.mode == PIM_MODE_STOP2 |=> o_cal_lp1 == $past(i_cal_alarm))
        else $error("calendar alarm lost in stop 2");

    clk_meas_a: assert property (
        gate.en_active |=> o_clk_meas == $past(i_clk_src))
        else $error("clock measure route wrong");

    sof_trig_a: assert property (
        gate.mode == PIM_MODE_LP_RUN |=> !o_sof_trig)
        else $error("frame start leaked in low-power run");

    break_or_a: assert property (
        gate.en_active && i_hard_fault |=> o_break_adv && o_break_small)
        else $error("fault did not break timers");

    stop2_block_a: assert property (
        gate.mode == PIM_MODE_STOP2
        |=> o_comp_lp2 == '0 && o_cal_lp2 == '0 && o_pin_lp2 == '0)
        else $error("second low-power timer reached in stop 2");

    blocked_quiet_a: assert property (
        gate.mode == PIM_MODE_STOP0 |=> !o_break_adv && o_pin_timer == '0)
        else $error("blocked path not held low");

    // Code 7 is ignored so a glitching mode bus cannot fall into stop
    unknown_hold_a: assert property (
        i_power_mode > PIM_CODE_STOP2 |=> $stable(gate.mode))
        else $error("unknown mode code changed the mode");

    xfer_pass_a: assert property (
        gate.en_active |=> o_xfer_trig == $past(i_timer_trgo))
        else $error("transfer trigger not passed");

    ir_block_a: assert property (
        !gate.en_active |=> o_ir_feed == '0)
        else $error("infrared feed leaked");

    comp_lp2_a: assert property (
        gate.en_lp2 |=> o_comp_lp2 == $past(i_comp_out))
        else $error("comparator to second low-power timer lost");

    awd_block_a: assert property (
        !gate.en_active |=> o_awd_trig == '0)
        else $error("watchdog trigger leaked");

    sof_pass_a: assert property (
        gate.en_full |=> o_sof_trig == $past(i_usb_sof))
        else $error("frame start not passed");

    break_block_a: assert property (
        !gate.en_active |=> !o_break_adv && !o_break_small)
        else $error("break leaked in stop");

    pin_lptim_a: assert property (
        gate.en_lp1 |=> o_pin_lp1 == $past(i_pin_trig))
        else $error("pin trigger to first low-power timer lost");

    run_sof_c: cover property (gate.en_full && i_usb_sof ##1 o_sof_trig);
    stop2_wake_c: cover property (
        gate.mode == PIM_MODE_STOP2 && i_comp_out != '0 ##1 o_comp_lp1 != '0);
    break_c: cover property (o_break_adv);
    mode_swap_c: cover property (
        gate.mode == PIM_MODE_RUN ##1 gate.mode == PIM_MODE_STOP1);
    unknown_hold_c: cover property (
        i_power_mode > PIM_CODE_STOP2 ##1 gate.mode == PIM_MODE_STOP2);

endmodule

// ### sim/pim_peripheral_model.sv
// Behavioural model of the peripherals that source routed events
`timescale 1ns/1ns
module pim_peripheral_model (
    // Event pattern from the bench
    input  wire logic [31:0] i_pattern,
    // Timer sources
    output logic      [7:0]  o_timer_trgo,
    output logic      [1:0]  o_timer_blank,
    output logic      [1:0]  o_small_tim_oc,
    // Analog, calendar, clock and pin sources
    output logic      [1:0]  o_comp_out,
    output logic      [2:0]  o_adc_awd,
    output logic             o_cal_event,
    output logic      [1:0]  o_cal_alarm,
    output logic      [5:0]  o_clk_src,
    output logic             o_usb_sof,
    output logic      [3:0]  o_pin_trig,
    // Fault sources
    output logic      [5:0]  o_fault
);
    // -----------------------------------------------------------------
    // Source levels
    // -----------------------------------------------------------------
    // Bit i of each source follows pattern bit i, so bit order shows up
    // at the destinations; faults sit apart so each can fire alone
    assign o_timer_trgo   = i_pattern[7:0];
    assign o_timer_blank  = i_pattern[1:0];
    assign o_small_tim_oc = i_pattern[1:0];
    assign o_comp_out     = i_pattern[1:0];
    assign o_adc_awd      = i_pattern[2:0];
    assign o_cal_event    = i_pattern[0];
    assign o_cal_alarm    = i_pattern[1:0];
    assign o_clk_src      = i_pattern[5:0];
    assign o_usb_sof      = i_pattern[0];
    assign o_pin_trig     = i_pattern[3:0];
    assign o_fault        = i_pattern[13:8];
endmodule

// ### sim/tb.sv
// Self-checking bench for the peripheral interconnect matrix
`timescale 1ns/1ns
module tb;
    import pim_pkg::*;
    logic        i_clk;
    logic        i_reset;
    logic [2:0]  power_mode;
    logic [31:0] pat;
    logic [7:0]  s_trgo, d_sync, d_xfer;
    logic [1:0]  s_blank, s_oc, s_comp, s_alarm, d_blank, d_ir, d_ctim;
    logic [1:0]  d_clp1, d_clp2, d_alp1, d_alp2;
    logic [2:0]  s_awd, d_awd;
    logic [5:0]  s_clk_src, s_fault, d_meas;
    logic [3:0]  s_pin, d_pin, d_plp1, d_plp2;
    logic        s_cal_ev, s_sof, d_cal, d_sof, d_badv, d_bsm;
    int          miscompares;
    int          samples_checked;

    pim_peripheral_model pim_peripheral_model_inst (
        .i_pattern(pat), .o_timer_trgo(s_trgo), .o_timer_blank(s_blank),
        .o_small_tim_oc(s_oc), .o_comp_out(s_comp), .o_adc_awd(s_awd),
        .o_cal_event(s_cal_ev), .o_cal_alarm(s_alarm),
        .o_clk_src(s_clk_src), .o_usb_sof(s_sof), .o_pin_trig(s_pin),
        .o_fault(s_fault));

    pim_matrix pim_matrix_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_power_mode(power_mode),
        .i_timer_trgo(s_trgo), .i_timer_blank(s_blank),
        .i_small_tim_oc(s_oc), .i_comp_out(s_comp), .i_adc_awd(s_awd),
        .i_cal_event(s_cal_ev), .i_cal_alarm(s_alarm),
        .i_clk_src(s_clk_src), .i_usb_sof(s_sof), .i_pin_trig(s_pin),
        .i_clk_fail(s_fault[0]), .i_hard_fault(s_fault[1]),
        .i_ram_parity(s_fault[2]), .i_flash_ecc(s_fault[3]),
        .i_pvd_event(s_fault[4]), .i_filter_fault(s_fault[5]),
        .o_timer_sync(d_sync), .o_xfer_trig(d_xfer),
        .o_comp_blank(d_blank), .o_ir_feed(d_ir), .o_comp_timer(d_ctim),
        .o_awd_trig(d_awd), .o_cal_timer(d_cal), .o_clk_meas(d_meas),
        .o_sof_trig(d_sof), .o_pin_timer(d_pin), .o_break_adv(d_badv),
        .o_break_small(d_bsm), .o_comp_lp1(d_clp1), .o_comp_lp2(d_clp2),
        .o_cal_lp1(d_alp1), .o_cal_lp2(d_alp2), .o_pin_lp1(d_plp1),
        .o_pin_lp2(d_plp2));

    always #20 i_clk = ~i_clk;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic summarize();
        $display("Checks made %0d, mismatches %0d", samples_checked,
                 miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Mode index m is the power mode code that the matrix tracks
    task automatic check_all(input int m, input logic [31:0] p);
        logic act, full, lp2, brk;
        act  = (m < 4);
        full = (m < 2);
        lp2  = (m != 6);
        brk  = act & ((|p[13:8]) | (|p[1:0]));
        check("timer_sync", d_sync, p[7:0] & {8{act}});
        check("xfer_trig", d_xfer, p[7:0] & {8{act}});
        check("comp_blank", d_blank, p[1:0] & {2{act}});
        check("ir_feed", d_ir, p[1:0] & {2{act}});
        check("comp_timer", d_ctim, p[1:0] & {2{act}});
        check("awd_trig", d_awd, p[2:0] & {3{act}});
        check("cal_timer", d_cal, p[0] & act);
        check("clk_meas", d_meas, p[5:0] & {6{act}});
        check("sof_trig", d_sof, p[0] & full);
        check("pin_timer", d_pin, p[3:0] & {4{act}});
        check("break_adv", d_badv, brk);
        check("break_small", d_bsm, brk);
        check("comp_lp1", d_clp1, p[1:0]);
        check("comp_lp2", d_clp2, p[1:0] & {2{lp2}});
        check("cal_lp1", d_alp1, p[1:0]);
        check("cal_lp2", d_alp2, p[1:0] & {2{lp2}});
        check("pin_lp1", d_plp1, p[3:0]);
        check("pin_lp2", d_plp2, p[3:0] & {4{lp2}});
    endtask

    // Code is taken at one edge and gates from the next; one more edge
    // of margin, then outputs are read at the falling edge
    task automatic settle(input logic [2:0] code, input logic [31:0] p);
        @(posedge i_clk);
        power_mode <= code;
        pat        <= p;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic sc_reset_quiet();
        @(negedge i_clk);
        check_all(0, 32'h0000_0000);
    endtask

    task automatic sc_mode_sweep();
        logic [31:0] pats [3];
        pats = '{32'hffff_ffff, 32'h0000_0155, 32'h0000_00aa};
        for (int m = 0; m < 7; m++) begin
            foreach (pats[i]) begin
                settle(3'(m), pats[i]);
                check_all(m, pats[i]);
            end
        end
    endtask

    task automatic sc_fault_breaks();
        logic [31:0] p;
        for (int k = 0; k < 6; k++) begin
            p = 32'h0000_0100 << k;
            settle(3'h0, p);
            check_all(0, p);
            settle(3'h4, p);
            check_all(4, p);
        end
    endtask

    task automatic sc_latency_and_block();
        settle(3'h0, 32'h0000_0000);
        @(posedge i_clk);
        pat <= 32'hffff_ffff;
        @(negedge i_clk);
        check("sync_early", d_sync, 32'h0000_0000);
        @(negedge i_clk);
        check("sync_late", d_sync, 32'h0000_00ff);
        @(posedge i_clk);
        power_mode <= 3'h5;
        @(negedge i_clk);
        check("sync_code_seen", d_sync, 32'h0000_00ff);
        @(negedge i_clk);
        check("sync_code_taken", d_sync, 32'h0000_00ff);
        @(negedge i_clk);
        check("sync_blocked", d_sync, 32'h0000_0000);
        check("comp_lp2_stop1", d_clp2, 32'h0000_0003);
    endtask

    task automatic sc_unknown_code();
        settle(3'h6, 32'hffff_ffff);
        settle(3'h7, 32'hffff_ffff);
        check_all(6, 32'hffff_ffff);
        settle(3'h1, 32'hffff_ffff);
        settle(3'h7, 32'hffff_ffff);
        check_all(1, 32'hffff_ffff);
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        miscompares     = 0;
        samples_checked = 0;
        i_clk           = 1'b0;
        i_reset         = 1'b1;
        power_mode      = 3'h3;
        pat             = 32'hffff_ffff;
        repeat (5) @(posedge i_clk);
        sc_reset_quiet();
        @(posedge i_clk);
        i_reset    <= 1'b0;
        power_mode <= 3'h0;
        pat        <= 32'h0000_0000;
        sc_mode_sweep();
        sc_fault_breaks();
        sc_latency_and_block();
        sc_unknown_code();
        summarize();
    end
endmodule
